// ===== logic/arc_pkg.sv
/*
 * arc_pkg: offsets, field positions, reset values and timing counts for the
 * readout control register group of the peak-sensing converter board.
 * assumes a 40 MHz board clock and 16-bit register data.
 */
//
// Overview of operation
// - two writable 8-bit registers hold base address bits 31..24 and 23..16
// - any write to the one-shot reset location resets the module
// - write-only first/last flags give chain role; upper bits ignored
// - interrupt request when stored events equal nonzero 5-bit threshold
// - read-only status shows buffer empty, buffer full and daughter-board code
// - 24-bit event counter read as 16-bit lower and 8-bit upper parts
// - mode bit 14 selects counting every trigger or accepted triggers only
// - counter clears on its reset strobe, module reset, data reset if accepted-only
// - write to next-event strobe moves readout pointer to next event
// - write to next-word strobe steps pointer one word, across trailer to next event
// - mode bit 11 selects automatic pointer stepping or strobe-only stepping
// - 10-bit N sets clear window to 7 us plus N/32 us, N at most 3c7
// - mode set register sets bits written as one, reads return mode state
// - memory-test bit enables direct buffer memory writes
// - converter-halt bit takes conversion controller offline
// - data-flush bit generates data reset of data, pointers, counter, peaks
// - overflow-check disable bit stores all conversions when set
// - threshold-check disable bit stores all data when set
// - threshold scale select picks threshold times 16 or times 2
// - acquisition-test bit takes stored data from internal test fifo
// - sliding-scale enable holds dac constant when clear; test bit disables subtraction
// - empty-event bit writes header and trailer when no channel accepted
// - mode clear register clears bits written as one
// - disabled sliding scale drives dac from separate 8-bit constant register
package arc_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] OFS_BASE_HI    = 16'h1012;
	localparam logic [15:0] OFS_BASE_LO    = 16'h1014;
	localparam logic [15:0] OFS_ONE_SHOT   = 16'h1016;
	localparam logic [15:0] OFS_CHAIN      = 16'h101a;
	localparam logic [15:0] OFS_IRQ_THR    = 16'h1020;
	localparam logic [15:0] OFS_BUF_STAT   = 16'h1022;
	localparam logic [15:0] OFS_CNT_LO     = 16'h1024;
	localparam logic [15:0] OFS_CNT_HI     = 16'h1026;
	localparam logic [15:0] OFS_NEXT_EVT   = 16'h1028;
	localparam logic [15:0] OFS_NEXT_WORD  = 16'h102a;
	localparam logic [15:0] OFS_CLR_WIN    = 16'h102e;
	localparam logic [15:0] OFS_MODE_SET   = 16'h1032;
	localparam logic [15:0] OFS_MODE_CLR   = 16'h1034;
	localparam logic [15:0] OFS_CNT_RESET  = 16'h1040;
	localparam logic [15:0] OFS_SLIDE_K    = 16'h106a;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CHAIN_FIRST_BIT = 0;
	localparam int CHAIN_LAST_BIT  = 1;
	localparam int STAT_EMPTY_BIT  = 0;
	localparam int STAT_FULL_BIT   = 1;
	localparam int STAT_TYPE_LSB   = 4;
	localparam int M_MEM_TEST      = 0;
	localparam int M_OFFLINE       = 1;
	localparam int M_CLEAR_DATA    = 2;
	localparam int M_OVR_OFF       = 3;
	localparam int M_THR_OFF       = 4;
	localparam int M_SYNTHETIC_EVENT_SOURCE      = 6;
	localparam int M_SLIDE_EN      = 7;
	localparam int M_THR_SCALE     = 8;
	localparam int M_SELF_STEP     = 11;
	localparam int M_EMPTY_EVT     = 12;
	localparam int M_SLIDE_SUB_OFF = 13;
	localparam int M_EVERY_TRG     = 14;
	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic [15:0] MODE_RESET    = 16'h4880;
	localparam logic [15:0] MODE_USED     = 16'h79df;
	localparam logic [9:0]  CLR_N_MAX     = 10'h3c7;
	localparam logic [9:0]  CLR_N_RESET   = 10'h000;
	localparam int          CLK_PS        = 25000;
	localparam int          CLR_BASE_PS   = 7000000;
	localparam int          CLR_STEP_PS   = 31250;
	localparam int          CLR_BASE_CYC  = CLR_BASE_PS / CLK_PS;
endpackage

// ===== logic/arc_ctrl_regs.sv
/*
 * arc_ctrl_regs: control and status register group of the converter board:
 * base address relocation, one-shot reset, chain role, event interrupt
 * threshold, buffer status, event counter, pointer strobes, clear window and
 * the set/clear operating-mode register.
 * assumes a same-clock register port driven by the bus interface (one-cycle
 * read and write strobes) and same-clock status and trigger pulses from the
 * front end and output buffer; only the daughter-board straps are foreign.
 */
`timescale 1ns/1ps
module arc_ctrl_regs
	import arc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             reg_ack,
	input  wire logic        soft_reset_in,
	input  wire logic        data_reset_in,
	input  wire logic        trig_any,
	input  wire logic        trig_accepted,
	input  wire logic [5:0]  stored_events,
	input  wire logic        buf_empty,
	input  wire logic        buf_full,
	input  wire logic [3:0]  daughter_type,
	output logic      [7:0]  base_addr_hi,
	output logic      [7:0]  base_addr_lo,
	output logic             module_reset,
	output logic             chain_first,
	output logic             chain_last,
	output logic             irq_event_count,
	output logic             next_event_pulse,
	output logic             next_word_pulse,
	output logic             pointer_self_step,
	output logic      [10:0] clear_window_time,
	output logic             mem_test_mode,
	output logic             conv_offline,
	output logic             data_flush,
	output logic             store_overflow,
	output logic             store_all_thr,
	output logic             threshold_scale_sel,
	output logic             synthetic_event_source,
	output logic             slide_enable,
	output logic             slide_sub_off,
	output logic             write_empty_events,
	output logic      [7:0]  slide_dac_value
);
	// ****************************************
	// decode
	// ****************************************
	function automatic logic wr_at(input logic [15:0] ofs);
		return reg_wr && (reg_addr == ofs);
	endfunction

	logic [15:0] mode_r;
	logic [7:0]  base_hi_r;
	logic [7:0]  base_lo_r;
	logic [1:0]  chain_r;
	logic [4:0]  irq_thr_r;
	logic [23:0] evt_cnt_r;
	logic [9:0]  clr_n_r;
	logic [7:0]  slide_k_r;
	logic [3:0]  type_s1_r;
	logic [3:0]  type_s2_r;
	logic        one_shot;
	logic        cnt_clear;
	logic [9:0]  clr_n_nxt;
	logic [15:0] rdata_nxt;
	logic [31:0] clr_cyc;

	assign one_shot  = wr_at(OFS_ONE_SHOT);
	assign cnt_clear = wr_at(OFS_CNT_RESET) || one_shot || soft_reset_in ||
		(!mode_r[M_EVERY_TRG] && (mode_r[M_CLEAR_DATA] || data_reset_in));
	assign clr_n_nxt = (reg_wdata[9:0] > CLR_N_MAX) ? CLR_N_MAX : reg_wdata[9:0];
	assign clr_cyc   = (CLR_BASE_PS + 32'(clr_n_r) * CLR_STEP_PS) / CLK_PS;

	// ****************************************
	// daughter-board straps
	// ****************************************
	// the straps come from the piggy-back connector, not from this clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			type_s1_r <= 4'h0;
			type_s2_r <= 4'h0;
		end else begin
			type_s1_r <= daughter_type;
			type_s2_r <= type_s1_r;
		end
	end

	// ****************************************
	// mode register
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= MODE_RESET;
		end else if (wr_at(OFS_MODE_SET)) begin
			mode_r <= mode_r | (reg_wdata & MODE_USED);
		end else if (wr_at(OFS_MODE_CLR)) begin
			mode_r <= mode_r & ~reg_wdata;
		end
	end

	// ****************************************
	// plain read/write registers
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_hi_r <= 8'h00;
			base_lo_r <= 8'h00;
			irq_thr_r <= 5'h00;
			clr_n_r   <= CLR_N_RESET;
			slide_k_r <= 8'h00;
		end else begin
			if (wr_at(OFS_BASE_HI))
				base_hi_r <= reg_wdata[7:0];
			if (wr_at(OFS_BASE_LO))
				base_lo_r <= reg_wdata[7:0];
			if (wr_at(OFS_IRQ_THR))
				irq_thr_r <= reg_wdata[4:0];
			if (wr_at(OFS_CLR_WIN))
				clr_n_r <= clr_n_nxt;
			if (wr_at(OFS_SLIDE_K))
				slide_k_r <= reg_wdata[7:0];
		end
	end

	// chain role is write-only; bits 2..15 are dropped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			chain_r <= 2'b00;
		else if (wr_at(OFS_CHAIN))
			chain_r <= {reg_wdata[CHAIN_LAST_BIT], reg_wdata[CHAIN_FIRST_BIT]};
	end

	// ****************************************
	// event counter
	// ****************************************
	// clear beats a coincident count: a reset must leave zero behind
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			evt_cnt_r <= 24'h000000;
		else if (cnt_clear)
			evt_cnt_r <= 24'h000000;
		else if (mode_r[M_EVERY_TRG] ? trig_any : trig_accepted)
			evt_cnt_r <= evt_cnt_r + 24'h000001;
	end

	// ****************************************
	// strobes and interrupt
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			module_reset     <= 1'b0;
			next_event_pulse <= 1'b0;
			next_word_pulse  <= 1'b0;
			irq_event_count  <= 1'b0;
		end else begin
			module_reset     <= one_shot || soft_reset_in;
			next_event_pulse <= wr_at(OFS_NEXT_EVT);
			next_word_pulse  <= wr_at(OFS_NEXT_WORD);
			irq_event_count  <= (irq_thr_r != 5'h00) && (stored_events == {1'b0, irq_thr_r});
		end
	end

	// ****************************************
	// mode and setting outputs
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_addr_hi           <= 8'h00;
			base_addr_lo           <= 8'h00;
			chain_first            <= 1'b0;
			chain_last             <= 1'b0;
			pointer_self_step      <= MODE_RESET[M_SELF_STEP];
			clear_window_time      <= 11'(CLR_BASE_CYC);
			mem_test_mode          <= 1'b0;
			conv_offline           <= 1'b0;
			data_flush             <= 1'b0;
			store_overflow         <= 1'b0;
			store_all_thr          <= 1'b0;
			threshold_scale_sel    <= 1'b0;
			synthetic_event_source <= 1'b0;
			slide_enable           <= MODE_RESET[M_SLIDE_EN];
			slide_sub_off          <= 1'b0;
			write_empty_events     <= 1'b0;
			slide_dac_value        <= 8'h00;
		end else begin
			base_addr_hi           <= base_hi_r;
			base_addr_lo           <= base_lo_r;
			chain_first            <= chain_r[0];
			chain_last             <= chain_r[1];
			pointer_self_step      <= mode_r[M_SELF_STEP];
			clear_window_time      <= clr_cyc[10:0];
			mem_test_mode          <= mode_r[M_MEM_TEST];
			conv_offline           <= mode_r[M_OFFLINE];
			data_flush             <= mode_r[M_CLEAR_DATA];
			store_overflow         <= mode_r[M_OVR_OFF];
			store_all_thr          <= mode_r[M_THR_OFF];
			threshold_scale_sel    <= mode_r[M_THR_SCALE];
			synthetic_event_source <= mode_r[M_SYNTHETIC_EVENT_SOURCE];
			slide_enable           <= mode_r[M_SLIDE_EN];
			slide_sub_off          <= mode_r[M_SLIDE_SUB_OFF];
			write_empty_events     <= mode_r[M_EMPTY_EVT];
			slide_dac_value        <= slide_k_r;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// write-only and unmapped locations read as zero
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (reg_addr)
			OFS_BASE_HI:   rdata_nxt = {8'h00, base_hi_r};
			OFS_BASE_LO:   rdata_nxt = {8'h00, base_lo_r};
			OFS_IRQ_THR:   rdata_nxt = {11'h000, irq_thr_r};
			OFS_BUF_STAT: begin
				rdata_nxt[STAT_EMPTY_BIT]                   = buf_empty;
				rdata_nxt[STAT_FULL_BIT]                    = buf_full;
				rdata_nxt[STAT_TYPE_LSB +: 4]               = type_s2_r;
			end
			OFS_CNT_LO:    rdata_nxt = evt_cnt_r[15:0];
			OFS_CNT_HI:    rdata_nxt = {8'h00, evt_cnt_r[23:16]};
			OFS_CLR_WIN:   rdata_nxt = {6'h00, clr_n_r};
			OFS_MODE_SET:  rdata_nxt = mode_r;
			OFS_SLIDE_K:   rdata_nxt = {8'h00, slide_k_r};
			default:       rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
		end else begin
			reg_ack <= reg_wr || reg_rd;
			if (reg_rd)
				reg_rdata <= rdata_nxt;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_base_hi_load: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_BASE_HI) |-> ##2 base_addr_hi == $past(reg_wdata[7:0], 2))
		else $error("base address high not loaded");

	a_one_shot_rst: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_ONE_SHOT) |=> module_reset && evt_cnt_r == 24'h000000)
		else $error("one-shot write did not reset");

	a_chain_flags: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_CHAIN) |-> ##2 {chain_last, chain_first} == $past(reg_wdata[1:0], 2))
		else $error("chain flags wrong");

	a_irq_thr_zero: assert property (@(posedge clk) disable iff (!rstn)
		irq_event_count |-> $past(irq_thr_r) != 5'h00 && $past(stored_events) == {1'b0, $past(irq_thr_r)})
		else $error("event interrupt without threshold match");

	a_count_mode: assert property (@(posedge clk) disable iff (!rstn)
		!cnt_clear && !mode_r[M_EVERY_TRG] && trig_any && !trig_accepted |=> $stable(evt_cnt_r))
		else $error("accepted-only counter took a plain trigger");

	a_cnt_step: assert property (@(posedge clk) disable iff (!rstn)
		!cnt_clear && mode_r[M_EVERY_TRG] && trig_any |=> evt_cnt_r == $past(evt_cnt_r) + 24'h000001)
		else $error("event counter did not step");

	a_cnt_clear: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_CNT_RESET) |=> evt_cnt_r == 24'h000000)
		else $error("counter reset strobe ignored");

	a_next_evt: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_NEXT_EVT) |=> next_event_pulse ##1 !next_event_pulse || $past(wr_at(OFS_NEXT_EVT)))
		else $error("next-event pulse wrong");

	a_next_word: assert property (@(posedge clk) disable iff (!rstn)
		next_word_pulse |-> $past(wr_at(OFS_NEXT_WORD)))
		else $error("spurious next-word pulse");

	a_win_limit: assert property (@(posedge clk) disable iff (!rstn)
		clr_n_r <= CLR_N_MAX)
		else $error("clear window count above limit");

	a_mode_set: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_MODE_SET) |=> (mode_r & $past(reg_wdata & MODE_USED)) == $past(reg_wdata & MODE_USED)
			&& (mode_r & $past(mode_r)) == $past(mode_r))
		else $error("mode set lost a bit");

	a_mode_clear: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_MODE_CLR) |=> mode_r == ($past(mode_r) & ~$past(reg_wdata)))
		else $error("mode clear wrong");

	a_self_step: assert property (@(posedge clk) disable iff (!rstn)
		$rose(mode_r[M_SELF_STEP]) |=> pointer_self_step)
		else $error("self-step output lags mode");

	a_halt_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 conv_offline == $past(mode_r[M_OFFLINE]))
		else $error("offline output wrong");

	a_irq_match: assert property (@(posedge clk) disable iff (!rstn)
		(irq_thr_r != 5'h00) && (stored_events == {1'b0, irq_thr_r}) |=> irq_event_count)
		else $error("event interrupt missed at threshold");

	a_status_read: assert property (@(posedge clk) disable iff (!rstn)
		reg_rd && (reg_addr == OFS_BUF_STAT) |=> reg_rdata[STAT_EMPTY_BIT] == $past(buf_empty)
			&& reg_rdata[STAT_FULL_BIT] == $past(buf_full))
		else $error("buffer status read wrong");

	a_mem_test_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 mem_test_mode == $past(mode_r[M_MEM_TEST]))
		else $error("memory test output wrong");

	a_flush_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 data_flush == $past(mode_r[M_CLEAR_DATA]))
		else $error("data flush output wrong");

	a_ovr_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 store_overflow == $past(mode_r[M_OVR_OFF]))
		else $error("overflow store output wrong");

	a_thr_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 store_all_thr == $past(mode_r[M_THR_OFF]))
		else $error("threshold store output wrong");

	a_scale_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 threshold_scale_sel == $past(mode_r[M_THR_SCALE]))
		else $error("threshold scale output wrong");

	a_synthetic_event_source_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 synthetic_event_source == $past(mode_r[M_SYNTHETIC_EVENT_SOURCE]))
		else $error("test source output wrong");

	a_slide_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 slide_enable == $past(mode_r[M_SLIDE_EN]) && slide_sub_off == $past(mode_r[M_SLIDE_SUB_OFF]))
		else $error("sliding scale outputs wrong");

	a_empty_out: assert property (@(posedge clk) disable iff (!rstn)
		##1 write_empty_events == $past(mode_r[M_EMPTY_EVT]))
		else $error("empty event output wrong");

	a_slide_const: assert property (@(posedge clk) disable iff (!rstn)
		wr_at(OFS_SLIDE_K) |-> ##2 slide_dac_value == $past(reg_wdata[7:0], 2))
		else $error("slide constant not loaded");
endmodule

// ===== verification/arc_bus_master.sv
/*
 * arc_bus_master: register-port master standing in for the bus cpu.
 * assumes one bench process calls wr and rd; signals change at the falling edge.
 */
`timescale 1ns/1ps
module arc_bus_master (
	input  wire logic        clk,
	output logic      [15:0] reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack
);
	int ack_miss = 0;
	initial begin
		reg_addr = 16'hffff;
		reg_wdata = 16'h5555;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ****************************************
	// accesses
	// ****************************************
	// idle address and data are inverted so a stale value never passes for a request
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		// acknowledge stands only for the cycle after the edge that took the strobe
		if (reg_ack !== 1'b1) ack_miss++;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		// two more cycles let mirrored outputs settle
		repeat (2) @(negedge clk);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		if (reg_ack !== 1'b1) ack_miss++;
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clk);
	endtask
endmodule

// ===== verification/tb_adc_readout_control_regs.sv
/*
 * tb_adc_readout_control_regs: self-checking bench for the control register group.
 * assumes arc_pkg and the bus master model; inputs change at the falling edge.
 */
`timescale 1ns/1ps
module tb_adc_readout_control_regs;
	import arc_pkg::*;
	localparam logic [15:0] OUT_MASK = MODE_USED & 16'hbfff;
	logic        clk, rstn, soft_reset_in, data_reset_in, trig_any, trig_accepted, buf_empty, buf_full;
	logic [5:0]  stored_events;
	logic [3:0]  daughter_type;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, mode_out;
	logic        reg_wr, reg_rd, reg_ack, module_reset, chain_first, chain_last, irq_event_count;
	logic        next_event_pulse, next_word_pulse, pointer_self_step, mem_test_mode, conv_offline;
	logic        data_flush, store_overflow, store_all_thr, threshold_scale_sel, synthetic_event_source;
	logic        slide_enable, slide_sub_off, write_empty_events;
	logic [7:0]  base_addr_hi, base_addr_lo, slide_dac_value;
	logic [10:0] clear_window_time;
	int          fail_count = 0, cmp_count = 0, cyc = 0, ne_cnt = 0, nw_cnt = 0, mr_cnt = 0;
	assign mode_out = {2'b00, slide_sub_off, write_empty_events, pointer_self_step, 2'b00, threshold_scale_sel,
		slide_enable, synthetic_event_source, 1'b0, store_all_thr, store_overflow, data_flush, conv_offline,
		mem_test_mode};
	arc_bus_master m_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
	arc_ctrl_regs arc_ctrl_regs_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.soft_reset_in(soft_reset_in), .data_reset_in(data_reset_in), .trig_any(trig_any),
		.trig_accepted(trig_accepted), .stored_events(stored_events), .buf_empty(buf_empty),
		.buf_full(buf_full), .daughter_type(daughter_type), .base_addr_hi(base_addr_hi),
		.base_addr_lo(base_addr_lo), .module_reset(module_reset), .chain_first(chain_first),
		.chain_last(chain_last), .irq_event_count(irq_event_count), .next_event_pulse(next_event_pulse),
		.next_word_pulse(next_word_pulse), .pointer_self_step(pointer_self_step),
		.clear_window_time(clear_window_time), .mem_test_mode(mem_test_mode), .conv_offline(conv_offline),
		.data_flush(data_flush), .store_overflow(store_overflow), .store_all_thr(store_all_thr),
		.threshold_scale_sel(threshold_scale_sel), .synthetic_event_source(synthetic_event_source),
		.slide_enable(slide_enable), .slide_sub_off(slide_sub_off), .write_empty_events(write_empty_events),
		.slide_dac_value(slide_dac_value));
	// ****************************************
	// clock, pulse tallies and hang guard
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (next_event_pulse === 1'b1) ne_cnt++;
		if (next_word_pulse === 1'b1) nw_cnt++;
		if (module_reset === 1'b1) mr_cnt++;
		if (cyc == 30000) begin
			fail_count++;
			$display("wrong value at %0t: run timed out", $time);
			print_verdict();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic trig(input logic a, input logic c, input int n);
		repeat (n) begin
			@(negedge clk);
			trig_any = a;
			trig_accepted = c;
			@(negedge clk);
			trig_any = 1'b0;
			trig_accepted = 1'b0;
		end
	endtask
	task automatic pulse_in(input int which);
		@(negedge clk);
		if (which == 0) data_reset_in = 1'b1;
		else soft_reset_in = 1'b1;
		@(negedge clk);
		data_reset_in = 1'b0;
		soft_reset_in = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic cnt_chk(input logic [15:0] exp);
		logic [15:0] d;
		m_i.rd(OFS_CNT_LO, d);
		chk(d, exp, "count lower");
		m_i.rd(OFS_CNT_HI, d);
		chk(d, 16'h0, "count upper");
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [15:0] d;
		m_i.rd(OFS_MODE_SET, d);
		chk(d, MODE_RESET, "mode after reset");
		chk(mode_out, MODE_RESET & OUT_MASK, "mode outputs after reset");
		m_i.rd(16'h1000, d);
		chk(d, 16'h0, "unmapped read");
		$display("test reset done");
	endtask
	task automatic t_mode;
		logic [15:0] d;
		for (int i = 0; i < 16; i++) begin
			m_i.wr(OFS_MODE_CLR, 16'hffff);
			m_i.wr(OFS_MODE_SET, 16'h1 << i);
			m_i.wr(OFS_MODE_SET, 16'h0);
			m_i.rd(OFS_MODE_SET, d);
			chk(d, (16'h1 << i) & MODE_USED, "mode bit set");
			chk(mode_out, (16'h1 << i) & OUT_MASK, "mode outputs");
		end
		m_i.wr(OFS_MODE_SET, 16'hffff);
		m_i.wr(OFS_MODE_CLR, MODE_USED & ~MODE_RESET);
		m_i.rd(OFS_MODE_SET, d);
		chk(d, MODE_RESET, "mode partial clear");
		$display("test mode done");
	endtask
	task automatic t_counter;
		trig(1'b1, 1'b1, 2);
		trig(1'b1, 1'b0, 3);
		cnt_chk(16'd5);
		pulse_in(0);
		cnt_chk(16'd5);
		m_i.wr(OFS_MODE_CLR, 16'h4000);
		trig(1'b1, 1'b0, 2);
		trig(1'b1, 1'b1, 1);
		cnt_chk(16'd6);
		pulse_in(0);
		cnt_chk(16'd0);
		trig(1'b1, 1'b1, 4);
		cnt_chk(16'd4);
		m_i.wr(OFS_CNT_RESET, 16'h0);
		cnt_chk(16'd0);
		m_i.wr(OFS_MODE_SET, 16'h4000);
		$display("test counter done");
	endtask
	task automatic t_resets;
		logic [15:0] d;
		int n;
		trig(1'b1, 1'b1, 3);
		n = mr_cnt;
		m_i.wr(OFS_ONE_SHOT, 16'ha5a5);
		chk(16'(mr_cnt - n), 16'h1, "one-shot reset pulse");
		cnt_chk(16'd0);
		trig(1'b1, 1'b1, 2);
		pulse_in(1);
		cnt_chk(16'd0);
		m_i.wr(OFS_MODE_SET, 16'h3001);
		trig(1'b1, 1'b1, 2);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		cnt_chk(16'd0);
		m_i.rd(OFS_MODE_SET, d);
		chk(d, MODE_RESET, "mode after hardware reset");
		chk(mode_out, MODE_RESET & OUT_MASK, "mode outputs after hardware reset");
		$display("test resets done");
	endtask
	task automatic t_strobes;
		int n;
		int w;
		n = ne_cnt;
		w = nw_cnt;
		m_i.wr(OFS_NEXT_EVT, 16'h0);
		m_i.wr(OFS_NEXT_WORD, 16'hffff);
		m_i.wr(OFS_NEXT_WORD, 16'h1);
		chk(16'(ne_cnt - n), 16'h1, "next event pulses");
		chk(16'(nw_cnt - w), 16'h2, "next word pulses");
		$display("test strobes done");
	endtask
	task automatic t_regs;
		logic [15:0] d;
		int          win [4] = '{0, 16, 967, 1023};
		int          n;
		m_i.wr(OFS_BASE_HI, 16'h12ab);
		m_i.wr(OFS_BASE_LO, 16'h34cd);
		chk({base_addr_hi, base_addr_lo}, 16'habcd, "base outputs");
		m_i.rd(OFS_BASE_LO, d);
		chk(d & 16'h00ff, 16'h00cd, "base readback");
		for (int i = 0; i < 4; i++) begin
			m_i.wr(OFS_CHAIN, 16'hfffc | 16'(i));
			chk({14'h0, chain_last, chain_first}, 16'(i), "chain role");
		end
		for (int i = 0; i < 4; i++) begin
			n = (win[i] > 967) ? 967 : win[i];
			m_i.wr(OFS_CLR_WIN, 16'(win[i]));
			m_i.rd(OFS_CLR_WIN, d);
			chk(d, 16'(n), "window value");
			chk(16'(clear_window_time), 16'((7000000 + n * 31250) / 25000), "window cycles");
		end
		m_i.wr(OFS_SLIDE_K, 16'h005a);
		m_i.rd(OFS_SLIDE_K, d);
		chk(d, 16'h005a, "slide readback");
		chk(16'(slide_dac_value), 16'h005a, "slide output");
		$display("test registers done");
	endtask
	task automatic t_irq_status;
		logic [15:0] d;
		m_i.wr(OFS_IRQ_THR, 16'h0003);
		for (int i = 2; i < 5; i++) begin
			stored_events = 6'(i);
			repeat (3) @(negedge clk);
			chk(16'(irq_event_count), 16'(i == 3), "irq at threshold");
		end
		m_i.rd(OFS_IRQ_THR, d);
		chk(d, 16'h0003, "threshold readback");
		m_i.wr(OFS_IRQ_THR, 16'h0);
		stored_events = 6'd0;
		repeat (3) @(negedge clk);
		chk(16'(irq_event_count), 16'h0, "zero threshold");
		for (int i = 0; i < 2; i++) begin
			buf_empty = (i == 0);
			buf_full = (i == 1);
			daughter_type = (i == 0) ? 4'ha : 4'h5;
			repeat (4) @(negedge clk);
			m_i.rd(OFS_BUF_STAT, d);
			chk(d, (16'(daughter_type) << STAT_TYPE_LSB) | (16'(buf_empty) << STAT_EMPTY_BIT)
				| (16'(buf_full) << STAT_FULL_BIT), "buffer status");
		end
		$display("test irq and status done");
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		{soft_reset_in, data_reset_in, trig_any, trig_accepted, buf_empty, buf_full} = 6'h0;
		stored_events = 6'd0;
		daughter_type = 4'h0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_mode();
		t_counter();
		t_resets();
		t_strobes();
		t_regs();
		t_irq_status();
		chk(16'(m_i.ack_miss), 16'h0, "missing acknowledges");
		print_verdict();
	end
endmodule
